// File: include/wdog_sup_consts.vh
// Offsets, reset values and timing counts for the watchdog supervisor
`ifndef WDOG_SUP_CONSTS_VH
`define WDOG_SUP_CONSTS_VH
`define CLK_HZ 40000000
`define REG_FLAGS 8'h00
`define REG_WDOG 8'h04
`define REG_CTRL 8'h08
`define REG_ALARM 8'h0C
`define FLAGS_WDF_BIT 7
`define FLAGS_AF_BIT 6
`define FLAGS_BL_BIT 4
`define CTRL_FT_BIT 0
`define CTRL_HOLD_BIT 1
`define CTRL_LATCH_BIT 2
`define ALARM_AFE_BIT 0
`define ALARM_ABE_BIT 1
`define WDOG_RST 8'h00
`define CTRL_RST 8'h00
`define ALARM_RST 8'h00
`define TICK16_MS_NUM 1000
`define TICK16_MS_DEN 16
`define EXT_RESET_IN_QUAL_MS 20
`define RST_HOLD_MS 40
`define RST_HOLD_MAX_MS 200
`define BATT_PERIOD_H 24
`define FT_HZ 512
`endif

// File: hw/wdog_reset_supervisor.v
// Watchdog, reset timing, battery check and flags behind AXI4-Lite
`timescale 1ns/100ps
`default_nettype none
`include "wdog_sup_consts.vh"

module wdog_reset_supervisor #(
    parameter TICK16_CYC = `CLK_HZ / 1000 * `TICK16_MS_NUM / `TICK16_MS_DEN,
    parameter QUAL_CYC = `CLK_HZ / 1000 * `EXT_RESET_IN_QUAL_MS,
    parameter HOLD_CYC = `CLK_HZ / 1000 * `RST_HOLD_MS,
    parameter BATT_SEC = `BATT_PERIOD_H * 3600,
    parameter SEC_CYC = `CLK_HZ,
    parameter FT_HALF_CYC = `CLK_HZ / (2 * `FT_HZ)
) (
    input wire i_core_clk,
    input wire i_rst_b,
    input wire i_wdog_kick_in,
    input wire i_ext_reset_in,
    input wire i_power_ok,
    input wire i_battery_below,
    input wire i_alarm_match,
    input wire [31:0] i_awaddr,
    input wire i_awvalid,
    output wire o_awready,
    input wire [31:0] i_wdata,
    input wire [3:0] i_wstrb,
    input wire i_wvalid,
    output wire o_wready,
    output wire [1:0] o_bresp,
    output wire o_bvalid,
    input wire i_bready,
    input wire [31:0] i_araddr,
    input wire i_arvalid,
    output wire o_arready,
    output wire [31:0] o_rdata,
    output wire [1:0] o_rresp,
    output wire o_rvalid,
    input wire i_rready,
    output wire o_sys_reset_out,
    output wire o_sys_reset_oe,
    output wire o_irq_freqtest_out,
    output wire o_irq_freqtest_oe
);
    // Wide enough for one second at any sane clock
    function [31:0] ms_left;
        input [31:0] v;
        begin
            ms_left = (v == 32'h0) ? 32'h0 : v - 32'h1;
        end
    endfunction

    // Pin synchronisers, first stage feeds only the second
    reg [4:0] s1_ff, s2_ff;
    always @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            s1_ff <= 5'h00;
            s2_ff <= 5'h00;
        end else begin
            s1_ff <= {i_alarm_match, i_battery_below, i_power_ok,
                      i_ext_reset_in, i_wdog_kick_in};
            s2_ff <= s1_ff;
        end
    end
    wire kick_s = s2_ff[0];
    wire ext_reset_in_s = s2_ff[1];
    wire pwr_s = s2_ff[2];
    wire batt_s = s2_ff[3];
    wire alarm_s = s2_ff[4];
    reg kick_d_ff, pwr_d_ff;

    // AXI4-Lite slave, one write and one read at a time
    reg aw_ff, w_ff, bvalid_ff, arready_ff, rvalid_ff;
    reg [7:0] awaddr_ff;
    reg [31:0] wdata_ff, rdata_ff;
    reg [3:0] wstrb_ff;
    reg [1:0] bresp_ff, rresp_ff;
    wire wr_go = aw_ff && w_ff && !bvalid_ff;
    wire ar_take = i_arvalid && arready_ff;
    wire wr_wdog = wr_go && awaddr_ff == `REG_WDOG && wstrb_ff[0];
    wire wr_ctrl = wr_go && awaddr_ff == `REG_CTRL && wstrb_ff[0];
    wire wr_alarm = wr_go && awaddr_ff == `REG_ALARM && wstrb_ff[0];
    wire rd_flags = ar_take && i_araddr[7:0] == `REG_FLAGS
                    && i_araddr[31:8] == 24'h000000;
    assign o_awready = !aw_ff;
    assign o_wready = !w_ff;
    assign o_bvalid = bvalid_ff;
    assign o_bresp = bresp_ff;
    assign o_arready = arready_ff;
    assign o_rvalid = rvalid_ff;
    assign o_rdata = rdata_ff;
    assign o_rresp = rresp_ff;

    // Register state
    reg [7:0] wdog_ff, ctrl_ff, alarm_ff;
    reg wdog_expired_flag_ff, battery_low_flag_ff, alarm_flag_ff;
    reg irq_wd_ff, wd_armed_ff;
    reg [31:0] tick_cnt_ff, wd_cnt_ff;
    wire [4:0] timeout_multiplier = wdog_ff[6:2];
    wire [1:0] timeout_resolution = wdog_ff[1:0];
    wire wdog_steer = wdog_ff[7];

    // Reset sequencing: 0 idle, 1 qualify, 2 hold low, 3 release wait
    localparam RS_IDLE = 2'b00;
    localparam RS_QUAL = 2'b01;
    localparam RS_LOW = 2'b10;
    localparam RS_REL = 2'b11;
    reg [1:0] rs_ff;
    reg [31:0] rs_cnt_ff;
    reg wd_pulse_ff;
    reg rst_low_ff;
    wire wd_expire = wd_armed_ff && (timeout_multiplier != 5'h00)
                     && wd_cnt_ff == 32'h0 && tick_cnt_ff == 32'h0;
    wire kick_edge = kick_s ^ kick_d_ff;

    // Bus channel handshakes and read mux
    always @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            aw_ff <= 1'b0;
            w_ff <= 1'b0;
            awaddr_ff <= 8'h00;
            wdata_ff <= 32'h00000000;
            wstrb_ff <= 4'h0;
            bvalid_ff <= 1'b0;
            bresp_ff <= 2'b00;
            arready_ff <= 1'b1;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h00000000;
            rresp_ff <= 2'b00;
        end else begin
            if (i_awvalid && !aw_ff) begin
                aw_ff <= 1'b1;
                awaddr_ff <= (i_awaddr[31:8] == 24'h000000) ?
                             i_awaddr[7:0] : 8'hFF;
            end
            if (i_wvalid && !w_ff) begin
                w_ff <= 1'b1;
                wdata_ff <= i_wdata;
                wstrb_ff <= i_wstrb;
            end
            if (wr_go) begin
                aw_ff <= 1'b0;
                w_ff <= 1'b0;
                bvalid_ff <= 1'b1;
                bresp_ff <= (awaddr_ff == `REG_WDOG || awaddr_ff == `REG_CTRL
                    || awaddr_ff == `REG_ALARM || awaddr_ff == `REG_FLAGS)
                    ? 2'b00 : 2'b10;
            end else if (bvalid_ff && i_bready) begin
                bvalid_ff <= 1'b0;
            end
            if (ar_take) begin
                arready_ff <= 1'b0;
                rvalid_ff <= 1'b1;
                rresp_ff <= 2'b00;
                rdata_ff <= 32'h00000000;
                if (i_araddr[31:8] != 24'h000000) begin
                    rresp_ff <= 2'b10;
                end else begin
                    case (i_araddr[7:0])
                    `REG_FLAGS: rdata_ff[7:0] <= {wdog_expired_flag_ff,
                        alarm_flag_ff, 1'b0, battery_low_flag_ff, 4'h0};
                    `REG_WDOG: rdata_ff[7:0] <= wdog_ff;
                    `REG_CTRL: rdata_ff[7:0] <= ctrl_ff;
                    `REG_ALARM: rdata_ff[7:0] <= alarm_ff;
                    default: rresp_ff <= 2'b10;
                    endcase
                end
            end else if (rvalid_ff && i_rready) begin
                rvalid_ff <= 1'b0;
                arready_ff <= 1'b1;
            end
        end
    end

    // Watchdog: 1/16 s tick base, resolution scales ticks
    function [31:0] timeout_ticks;
        input [4:0] mult;
        input [1:0] res;
        begin
            case (res)
            2'b00: timeout_ticks = {27'h0, mult} - 32'h1;
            2'b01: timeout_ticks = {25'h0, mult, 2'b00} - 32'h1;
            2'b10: timeout_ticks = {23'h0, mult, 4'h0} - 32'h1;
            default: timeout_ticks = {21'h0, mult, 6'h00} - 32'h1;
            endcase
        end
    endfunction
    reg [31:0] nxt_wd_cnt;
    always @* begin
        nxt_wd_cnt = timeout_ticks(timeout_multiplier, timeout_resolution);
    end

    // Watchdog register, counter and flags
    always @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wdog_ff <= `WDOG_RST;
            ctrl_ff <= `CTRL_RST;
            alarm_ff <= `ALARM_RST;
            wd_armed_ff <= 1'b0;
            wd_cnt_ff <= 32'h0;
            tick_cnt_ff <= 32'h0;
            irq_wd_ff <= 1'b0;
            wdog_expired_flag_ff <= 1'b0;
            alarm_flag_ff <= 1'b0;
            kick_d_ff <= 1'b0;
            wd_pulse_ff <= 1'b0;
        end else begin
            kick_d_ff <= kick_s;
            wd_pulse_ff <= 1'b0;
            tick_cnt_ff <= (tick_cnt_ff == 32'h0) ? TICK16_CYC - 1
                           : tick_cnt_ff - 32'h1;
            if (tick_cnt_ff == 32'h0 && wd_armed_ff) begin
                wd_cnt_ff <= ms_left(wd_cnt_ff);
            end
            if (wr_ctrl) begin
                ctrl_ff <= {5'h00, wdata_ff[2:0]};
            end
            if (wr_alarm) begin
                alarm_ff <= {6'h00, wdata_ff[1:0]};
            end
            // Set wins over the read-clear in the same cycle
            if (rd_flags) begin
                wdog_expired_flag_ff <= 1'b0;
                alarm_flag_ff <= 1'b0;
            end
            if (alarm_s) begin
                alarm_flag_ff <= 1'b1;
            end
            if (wr_wdog) begin
                wdog_ff <= wdata_ff[7:0];
                wd_armed_ff <= wdata_ff[6:2] != 5'h00;
                tick_cnt_ff <= TICK16_CYC - 1;
                // Load straight from the new value, old one is stale
                wd_cnt_ff <= timeout_ticks(wdata_ff[6:2], wdata_ff[1:0]);
                if (wdata_ff[7:0] == 8'h00) begin
                    irq_wd_ff <= 1'b0;
                end
            end else if (kick_edge && wd_armed_ff) begin
                tick_cnt_ff <= TICK16_CYC - 1;
                wd_cnt_ff <= nxt_wd_cnt;
            end
            if (wd_expire) begin
                wdog_expired_flag_ff <= 1'b1;
                wd_armed_ff <= 1'b0;
                if (wdog_steer) begin
                    wd_pulse_ff <= 1'b1;
                    wdog_ff <= 8'h00;
                    ctrl_ff[`CTRL_FT_BIT] <= 1'b0;
                end else begin
                    irq_wd_ff <= 1'b1;
                end
            end
            if (!pwr_s) begin
                wdog_ff <= 8'h00;
                wd_armed_ff <= 1'b0;
            end
            if (pwr_s && !pwr_d_ff) begin
                wdog_ff <= 8'h00;
                ctrl_ff <= `CTRL_RST;
                alarm_ff <= `ALARM_RST;
                irq_wd_ff <= 1'b0;
            end
        end
    end

    // Reset output sequencer for power, pin and watchdog causes
    wire ext_reset_in_low = !ext_reset_in_s;
    always @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rs_ff <= RS_LOW;
            rs_cnt_ff <= 32'h0;
            rst_low_ff <= 1'b1;
            pwr_d_ff <= 1'b0;
        end else begin
            pwr_d_ff <= pwr_s;
            case (rs_ff)
            RS_IDLE: begin
                rst_low_ff <= 1'b0;
                if (!pwr_s || wd_pulse_ff) begin
                    rs_ff <= RS_LOW;
                    rst_low_ff <= 1'b1;
                end else if (ext_reset_in_low) begin
                    rs_ff <= RS_QUAL;
                    rs_cnt_ff <= QUAL_CYC - 1;
                end
            end
            RS_QUAL: begin
                // Supply loss or a watchdog pulse must not wait out the filter
                if (!pwr_s || wd_pulse_ff) begin
                    rs_ff <= RS_LOW;
                    rst_low_ff <= 1'b1;
                end else if (!ext_reset_in_low) begin
                    rs_ff <= RS_IDLE;
                end else if (rs_cnt_ff == 32'h0) begin
                    rs_ff <= RS_LOW;
                    rst_low_ff <= 1'b1;
                end else begin
                    rs_cnt_ff <= rs_cnt_ff - 32'h1;
                end
            end
            RS_LOW: begin
                rst_low_ff <= 1'b1;
                rs_cnt_ff <= HOLD_CYC - 1;
                if (pwr_s && !ext_reset_in_low) begin
                    rs_ff <= RS_REL;
                end
            end
            default: begin
                if (!pwr_s || ext_reset_in_low) begin
                    rs_ff <= RS_LOW;
                end else if (rs_cnt_ff == 32'h0) begin
                    rs_ff <= RS_IDLE;
                    rst_low_ff <= 1'b0;
                end else begin
                    rs_cnt_ff <= rs_cnt_ff - 32'h1;
                end
            end
            endcase
        end
    end

    // Battery check at power-up and every period, mains only
    reg [31:0] sec_cnt_ff, batt_cnt_ff;
    always @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sec_cnt_ff <= 32'h0;
            batt_cnt_ff <= 32'h0;
            battery_low_flag_ff <= 1'b0;
        end else if (!pwr_s) begin
            sec_cnt_ff <= 32'h0;
            batt_cnt_ff <= 32'h0;
        end else begin
            sec_cnt_ff <= (sec_cnt_ff == 32'h0) ? SEC_CYC - 1
                          : sec_cnt_ff - 32'h1;
            if (batt_cnt_ff == 32'h0) begin
                battery_low_flag_ff <= batt_s;
                batt_cnt_ff <= BATT_SEC;
            end else if (sec_cnt_ff == 32'h0) begin
                batt_cnt_ff <= batt_cnt_ff - 32'h1;
            end
        end
    end

    // Shared pin: irq sources override the 512 Hz test toggle
    reg [31:0] ft_cnt_ff;
    reg ft_ff, pin_low_ff;
    wire alarm_irq = alarm_flag_ff && alarm_ff[`ALARM_AFE_BIT];
    wire ft_ok = ctrl_ff[`CTRL_FT_BIT] && !alarm_ff[`ALARM_AFE_BIT]
                 && (wdog_steer || wdog_ff == 8'h00);
    always @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ft_cnt_ff <= 32'h0;
            ft_ff <= 1'b0;
            pin_low_ff <= 1'b0;
        end else begin
            ft_cnt_ff <= (ft_cnt_ff == 32'h0) ? FT_HALF_CYC - 1
                         : ft_cnt_ff - 32'h1;
            if (ft_cnt_ff == 32'h0) begin
                ft_ff <= !ft_ff;
            end
            if (irq_wd_ff || alarm_irq) begin
                pin_low_ff <= 1'b1;
            end else begin
                pin_low_ff <= ft_ok && !ft_ff;
            end
        end
    end

    // Open-drain pins drive low only
    assign o_sys_reset_out = 1'b0;
    assign o_sys_reset_oe = rst_low_ff;
    assign o_irq_freqtest_out = 1'b0;
    assign o_irq_freqtest_oe = pin_low_ff;
endmodule
`default_nettype wire

// File: testbench/host_kicker.sv
// Host model that toggles the watchdog kick pin while enabled
`timescale 1ns/100ps
`default_nettype none
module host_kicker #(
    parameter PERIOD = 4
) (
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic i_enable,
    output logic o_kick
);
    logic [7:0] cnt_ff;
    // Toggling gives both edge kinds; a stopped host holds its level
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cnt_ff <= 8'h00;
            o_kick <= 1'b0;
        end else if (i_enable) begin
            cnt_ff <= (cnt_ff == PERIOD - 1) ? 8'h00 : cnt_ff + 8'h01;
            if (cnt_ff == PERIOD - 1) begin
                o_kick <= ~o_kick;
            end
        end
    end
endmodule
`default_nettype wire

// File: testbench/wdog_sup_chk.sv
// Concurrent checks on the supervisor pins and bus handshakes
`timescale 1ns/100ps
`default_nettype none
module wdog_sup_chk #(
    parameter QUAL_CYC = 5
) (
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic i_ext_reset_in,
    input wire logic i_power_ok,
    input wire logic i_awvalid,
    input wire logic o_awready,
    input wire logic i_wvalid,
    input wire logic o_wready,
    input wire logic o_bvalid,
    input wire logic i_bready,
    input wire logic i_arvalid,
    input wire logic o_arready,
    input wire logic o_rvalid,
    input wire logic i_rready,
    input wire logic [31:0] o_rdata,
    input wire logic o_sys_reset_out,
    input wire logic o_irq_freqtest_out,
    input wire logic o_sys_reset_oe
);
    logic [7:0] low_cnt_ff;
    // Length of the current low stretch on the reset input, saturating
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            low_cnt_ff <= 8'h00;
        end else if (i_ext_reset_in || !i_power_ok) begin
            low_cnt_ff <= 8'h00;
        end else if (low_cnt_ff != 8'hFF) begin
            low_cnt_ff <= low_cnt_ff + 8'h01;
        end
    end
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_b);
    a_pins_open_drain: assert property (!o_sys_reset_out && !o_irq_freqtest_out)
        else $error("open drain pin drove high");
    a_rst_not_early: assert property ($fell(i_ext_reset_in) && i_power_ok &&
        !o_sys_reset_oe |-> ##1 (!o_sys_reset_oe)[*3])
        else $error("reset out asserted before qualification");
    a_rst_qualified: assert property (int'(low_cnt_ff) == QUAL_CYC + 6
        |-> o_sys_reset_oe)
        else $error("reset out missing after long input low");
    a_powerfail_rst: assert property (!i_power_ok |-> ##[0:3] o_sys_reset_oe)
        else $error("reset out missing on power fail");
    a_rst_hold_min: assert property ($rose(i_ext_reset_in) && o_sys_reset_oe
        |-> o_sys_reset_oe[*8])
        else $error("reset out released too early");
    a_rst_hold_max: assert property ($rose(i_ext_reset_in) && i_power_ok
        |-> ##[1:24] (!o_sys_reset_oe || !i_ext_reset_in || !i_power_ok))
        else $error("reset out held too long");
    a_bvalid_stands: assert property (o_bvalid && !i_bready |=> o_bvalid)
        else $error("write response dropped early");
    a_rvalid_stands: assert property (o_rvalid && !i_rready
        |=> o_rvalid && $stable(o_rdata))
        else $error("read data dropped early");
    a_read_answer: assert property (i_arvalid && o_arready |=> o_rvalid)
        else $error("read answer late");
    a_write_answer: assert property (i_awvalid && o_awready && i_wvalid &&
        o_wready |-> ##[1:2] o_bvalid)
        else $error("write answer late");
endmodule
bind wdog_reset_supervisor wdog_sup_chk #(.QUAL_CYC(QUAL_CYC)) u_chk (
    .i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
    .i_ext_reset_in(i_ext_reset_in), .i_power_ok(i_power_ok),
    .i_awvalid(i_awvalid), .o_awready(o_awready), .i_wvalid(i_wvalid),
    .o_wready(o_wready), .o_bvalid(o_bvalid), .i_bready(i_bready),
    .i_arvalid(i_arvalid), .o_arready(o_arready), .o_rvalid(o_rvalid),
    .i_rready(i_rready), .o_rdata(o_rdata), .o_sys_reset_out(o_sys_reset_out),
    .o_irq_freqtest_out(o_irq_freqtest_out), .o_sys_reset_oe(o_sys_reset_oe));
`default_nettype wire

// File: testbench/tb.sv
// Self-checking bench for the watchdog reset supervisor
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic i_core_clk = 1'b0, i_rst_b = 1'b0, i_ext_reset_in = 1'b1;
    logic i_power_ok = 1'b1, i_battery_below = 1'b0, kick_en = 1'b0;
    logic i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
    logic i_arvalid = 1'b0, i_rready = 1'b0, i_alarm_match = 1'b0;
    logic [1:0] last_bresp = 2'b00;
    logic [31:0] i_awaddr = 32'h0, i_wdata = 32'h0, i_araddr = 32'h0;
    logic [3:0] i_wstrb = 4'h0;
    wire logic kick, o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
    wire logic o_rst_out, o_rst_oe, o_irq_out, o_irq_oe;
    wire logic [1:0] o_bresp, o_rresp;
    wire logic [31:0] o_rdata;
    int errors = 0, samples_checked = 0, cycles = 0;
    always #12.5 i_core_clk = ~i_core_clk;
    host_kicker u_kick (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
        .i_enable(kick_en), .o_kick(kick));
    // Short counts keep timing within a few cycles; zero battery period
    // makes every powered cycle a battery check
    wdog_reset_supervisor #(.TICK16_CYC(4), .QUAL_CYC(5), .HOLD_CYC(8),
        .BATT_SEC(0), .FT_HALF_CYC(4)) dut (
        .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_wdog_kick_in(kick),
        .i_ext_reset_in(i_ext_reset_in), .i_power_ok(i_power_ok),
        .i_battery_below(i_battery_below), .i_alarm_match(i_alarm_match),
        .i_awaddr(i_awaddr), .i_awvalid(i_awvalid), .o_awready(o_awready),
        .i_wdata(i_wdata), .i_wstrb(i_wstrb), .i_wvalid(i_wvalid),
        .o_wready(o_wready), .o_bresp(o_bresp), .o_bvalid(o_bvalid),
        .i_bready(i_bready), .i_araddr(i_araddr), .i_arvalid(i_arvalid),
        .o_arready(o_arready), .o_rdata(o_rdata), .o_rresp(o_rresp),
        .o_rvalid(o_rvalid), .i_rready(i_rready), .o_sys_reset_out(o_rst_out),
        .o_sys_reset_oe(o_rst_oe), .o_irq_freqtest_out(o_irq_out),
        .o_irq_freqtest_oe(o_irq_oe));
    task automatic tally_and_finish;
        $display("checked %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // Hang guard: tests need well under a thousand cycles
    always @(posedge i_core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            tally_and_finish();
        end
    end
    task automatic chk(input string what, input logic [31:0] e,
        input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge i_core_clk);
    endtask
    // Sampled at the falling edge, where design outputs are settled
    task automatic wait_pin(input bit irq, input logic want, input int max);
        int n;
        logic v;
        n = 0;
        do begin
            @(negedge i_core_clk);
            v = irq ? o_irq_oe : o_rst_oe;
            @(posedge i_core_clk);
            n++;
        end while (v !== want && n < max);
        chk(irq ? "irq pin" : "reset pin", {31'h0, want}, {31'h0, v});
    endtask
    task automatic axi_write(input logic [31:0] a, input logic [31:0] d);
        logic pa, pw, ha, hw;
        pa = 1'b1;
        pw = 1'b1;
        i_awaddr <= a;
        i_wdata <= d;
        i_wstrb <= 4'hF;
        i_awvalid <= 1'b1;
        i_wvalid <= 1'b1;
        while (pa || pw) begin
            @(negedge i_core_clk);
            ha = pa && o_awready;
            hw = pw && o_wready;
            @(posedge i_core_clk);
            if (ha) i_awvalid <= 1'b0;
            if (hw) i_wvalid <= 1'b0;
            pa = pa && !ha;
            pw = pw && !hw;
        end
        i_bready <= 1'b1;
        do begin
            @(negedge i_core_clk);
            ha = o_bvalid;
            last_bresp = o_bresp;
            @(posedge i_core_clk);
        end while (ha !== 1'b1);
        i_bready <= 1'b0;
    endtask
    task automatic axi_read(input logic [31:0] a, output logic [31:0] d,
        output logic [1:0] r);
        logic h;
        i_araddr <= a;
        i_arvalid <= 1'b1;
        i_rready <= 1'b1;
        do begin
            @(negedge i_core_clk);
            h = o_arready;
            @(posedge i_core_clk);
        end while (h !== 1'b1);
        i_arvalid <= 1'b0;
        do begin
            @(negedge i_core_clk);
            h = o_rvalid;
            d = o_rdata;
            r = o_rresp;
            @(posedge i_core_clk);
        end while (h !== 1'b1);
        i_rready <= 1'b0;
    endtask
    task automatic rd_bits(input logic [31:0] a, input logic [31:0] m,
        input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        axi_read(a, d, r);
        chk("read data", e, d & m);
    endtask
    task automatic t_regs;
        logic [31:0] d;
        logic [1:0] r;
        rd_bits(32'h04, 32'hFFFFFFFF, 32'h0);
        rd_bits(32'h08, 32'hFFFFFFFF, 32'h0);
        rd_bits(32'h0C, 32'hFFFFFFFF, 32'h0);
        axi_read(32'h10, d, r);
        chk("unmapped resp", 32'h2, {30'h0, r});
        axi_write(32'h10, 32'h5A);
        chk("unmapped bresp", 32'h2, {30'h0, last_bresp});
        $display("test regs done");
    endtask
    task automatic t_ext;
        i_ext_reset_in <= 1'b0;
        cyc(2);
        i_ext_reset_in <= 1'b1;
        cyc(15);
        wait_pin(0, 1'b0, 1);
        i_ext_reset_in <= 1'b0;
        wait_pin(0, 1'b1, 25);
        cyc(4);
        i_ext_reset_in <= 1'b1;
        cyc(4);
        wait_pin(0, 1'b1, 1);
        wait_pin(0, 1'b0, 30);
        $display("test ext reset done");
    endtask
    // Kicks every 4 cycles against a 16-cycle period, then silence
    task automatic t_wdog_irq;
        kick_en <= 1'b1;
        axi_write(32'h04, 32'h10);
        cyc(60);
        wait_pin(1, 1'b0, 1);
        kick_en <= 1'b0;
        cyc(8);
        wait_pin(1, 1'b0, 1);
        wait_pin(1, 1'b1, 40);
        rd_bits(32'h00, 32'h80, 32'h80);
        rd_bits(32'h00, 32'h80, 32'h0);
        wait_pin(1, 1'b1, 1);
        axi_write(32'h04, 32'h00);
        wait_pin(1, 1'b0, 4);
        cyc(60);
        wait_pin(1, 1'b0, 1);
        $display("test watchdog irq done");
    endtask
    task automatic t_sw_restart;
        repeat (8) begin
            axi_write(32'h04, 32'h10);
            cyc(4);
        end
        wait_pin(1, 1'b0, 1);
        axi_write(32'h04, 32'h08);
        wait_pin(1, 1'b1, 14);
        axi_write(32'h04, 32'h00);
        rd_bits(32'h00, 32'h80, 32'h80);
        $display("test soft restart done");
    endtask
    task automatic t_priority;
        axi_write(32'h08, 32'h01);
        axi_write(32'h04, 32'h10);
        wait_pin(1, 1'b1, 40);
        repeat (12) wait_pin(1, 1'b1, 1);
        axi_write(32'h04, 32'h00);
        axi_write(32'h08, 32'h00);
        rd_bits(32'h00, 32'h80, 32'h80);
        $display("test priority done");
    endtask
    // Test tone visible alone, then an alarm takes the shared pin
    task automatic t_alarm;
        axi_write(32'h08, 32'h01);
        wait_pin(1, 1'b1, 10);
        wait_pin(1, 1'b0, 10);
        axi_write(32'h0C, 32'h01);
        repeat (10) wait_pin(1, 1'b0, 1);
        i_alarm_match <= 1'b1;
        cyc(1);
        i_alarm_match <= 1'b0;
        wait_pin(1, 1'b1, 6);
        repeat (8) wait_pin(1, 1'b1, 1);
        rd_bits(32'h00, 32'h40, 32'h40);
        wait_pin(1, 1'b0, 4);
        axi_write(32'h0C, 32'h00);
        axi_write(32'h08, 32'h00);
        $display("test alarm done");
    endtask
    task automatic t_wdog_rst;
        axi_write(32'h08, 32'h01);
        axi_write(32'h04, 32'h88);
        wait_pin(0, 1'b1, 40);
        cyc(4);
        wait_pin(0, 1'b1, 1);
        wait_pin(0, 1'b0, 30);
        rd_bits(32'h04, 32'hFF, 32'h0);
        rd_bits(32'h08, 32'h01, 32'h0);
        rd_bits(32'h00, 32'h80, 32'h80);
        $display("test watchdog reset done");
    endtask
    task automatic t_power;
        axi_write(32'h04, 32'h7C);
        axi_write(32'h08, 32'h07);
        axi_write(32'h0C, 32'h03);
        i_power_ok <= 1'b0;
        wait_pin(0, 1'b1, 4);
        cyc(10);
        i_power_ok <= 1'b1;
        cyc(4);
        wait_pin(0, 1'b1, 1);
        wait_pin(0, 1'b0, 30);
        rd_bits(32'h04, 32'hFF, 32'h0);
        rd_bits(32'h08, 32'h07, 32'h0);
        rd_bits(32'h0C, 32'h03, 32'h0);
        $display("test power cycle done");
    endtask
    // Low battery during back-up goes unseen until mains returns
    task automatic t_batt;
        i_power_ok <= 1'b0;
        cyc(4);
        i_battery_below <= 1'b1;
        cyc(8);
        rd_bits(32'h00, 32'h10, 32'h0);
        i_power_ok <= 1'b1;
        cyc(8);
        rd_bits(32'h00, 32'h10, 32'h10);
        i_battery_below <= 1'b0;
        cyc(30);
        rd_bits(32'h00, 32'h10, 32'h0);
        $display("test battery done");
    endtask
    initial begin
        cyc(10);
        i_rst_b <= 1'b1;
        wait_pin(0, 1'b0, 30);
        t_regs();
        t_ext();
        t_wdog_irq();
        t_sw_restart();
        t_priority();
        t_alarm();
        t_wdog_rst();
        t_power();
        t_batt();
        tally_and_finish();
    end
endmodule
`default_nettype wire
